// [rtl/pcs_pkg.sv]
// constants, offsets and carrier types of the 16-bit socket setup bank
// assumes one host clock domain; card pins arrive unsynchronised
package pcs_pkg;

  // legacy port pair
  localparam logic [15:0] PORT_BASE_A   = 16'h03E0;
  localparam logic [15:0] PORT_BASE_B   = 16'h03E2;

  // index window selection
  localparam logic [1:0]  IDX_WIN_LOW   = 2'h0;
  localparam logic [1:0]  IDX_WIN_HIGH  = 2'h2;

  // register indices inside the window
  localparam logic [5:0]  IDX_IDENT     = 6'h00;
  localparam logic [5:0]  IDX_STATUS    = 6'h01;
  localparam logic [5:0]  IDX_POWER     = 6'h02;
  localparam logic [5:0]  IDX_INTGEN    = 6'h03;
  localparam logic [5:0]  IDX_CSC       = 6'h04;
  localparam logic [5:0]  IDX_CSCINT    = 6'h05;
  localparam logic [5:0]  IDX_GLOBAL    = 6'h1E;
  localparam logic [5:0]  IDX_MISC1     = 6'h2F;

  // field positions
  localparam int POW_DRIVE   = 7;
  localparam int POW_AUTO    = 5;
  localparam int POW_SUPPLY  = 4;
  localparam int IG_RING     = 7;
  localparam int IG_RESET    = 6;
  localparam int IG_IOCARD   = 5;
  localparam int GL_ACKMODE  = 2;
  localparam int CSC_CD      = 3;
  localparam int CSC_RDY     = 2;
  localparam int CSC_BWARN   = 1;
  localparam int CSC_BDEAD   = 0;

  // identification fields
  localparam logic [1:0]  IFACE_MEM_IO  = 2'h2;

  // values after reset
  localparam logic [7:0]  POWER_RST     = 8'h00;
  localparam logic [7:0]  INTGEN_RST    = 8'h00;
  localparam logic [7:0]  CSCINT_RST    = 8'h00;
  localparam logic [3:0]  GLOBAL_RST    = 4'h0;
  localparam logic [3:0]  CSC_RST       = 4'h0;
  localparam logic [7:0]  INDEX_RST     = 8'h00;

  // card pins, all raw from the socket
  typedef struct packed {
    logic ready;
    logic wp;
    logic cd1_n;
    logic cd2_n;
    logic bvd1_stschg_n;
    logic bvd2;
    logic ireq_n;
  } pcs_pins_t;

endpackage

// [rtl/pcs_socket_setup.sv]
// general setup and status bank of one 16-bit card socket, legacy port pair
// assumes host bus strobes on mclk; card pins asynchronous, synchronised here
module pcs_socket_setup #(
  parameter logic [3:0] REVISION = 4'h5 // arbitrary value
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // host io port
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic        io_wide,
  input  wire logic [15:0] io_wdata,
  output logic [7:0]       io_rdata_r,
  output logic             io_rvalid_r,
  // configuration space inputs and the card detect clear request output
  input  wire logic [15:0] legacy_base,
  input  wire logic        index_range_sel,
  input  wire logic        isa_irq_en,
  input  wire logic        mem_wp_bit,
  input  wire logic        evt_cd_cleared,
  output logic             evt_cd_clear_r,
  // card socket
  input  pcs_pkg::pcs_pins_t pins,
  output logic             supply_3v3_enable_n,
  output logic             supply_5v_enable_n,
  output logic             prog_voltage_enable_0,
  output logic             prog_voltage_enable_1,
  output logic             card_output_drive_enable,
  output logic             card_reset_r,
  output logic             card_write_block_r,
  output logic             ring_output_n,
  // system interrupts
  output logic [15:0]      card_irq_r,
  output logic [15:0]      status_change_irq_route_r,
  output logic             csc_inta_r
);

  function automatic logic [15:0] route(input logic [3:0] code);
    logic [15:0] v;
    v = 16'h0000;
    case (code)
      4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF: v[code] = 1'b1;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers; stage one feeds stage two only
  pcs_pkg::pcs_pins_t s1_r, s2_r, s3_r;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // port decode
  logic [7:0] index_r;
  logic [7:0] power_r, intgen_r, cscint_r;
  logic [3:0] global_r, csc_r;
  logic       misc1_r;
  logic       base_ok, hit_idx, hit_dat, wr_go, rd_dat;
  logic [7:0] wr_idx, wr_val, acc_idx;
  logic       win_ok;
  logic [5:0] reg_sel;

  assign base_ok = (legacy_base == pcs_pkg::PORT_BASE_A) ||
                   (legacy_base == pcs_pkg::PORT_BASE_B);
  assign hit_idx = base_ok && (io_addr == legacy_base);
  assign hit_dat = base_ok && (io_addr == legacy_base + 16'h0001);
  assign wr_idx  = (hit_idx && io_wide) ? io_wdata[7:0] : index_r;
  assign wr_val  = (hit_idx && io_wide) ? io_wdata[15:8] : io_wdata[7:0];
  assign acc_idx = io_wr ? wr_idx : index_r;
  assign win_ok  = acc_idx[7:6] == (index_range_sel ? pcs_pkg::IDX_WIN_HIGH
                                                    : pcs_pkg::IDX_WIN_LOW);
  assign reg_sel = acc_idx[5:0];
  assign wr_go   = io_wr && win_ok && (hit_dat || (hit_idx && io_wide));
  assign rd_dat  = io_rd && hit_dat && win_ok;

  always_ff @(posedge mclk) begin
    if (!nrst)
      index_r <= pcs_pkg::INDEX_RST;
    else if (io_wr && hit_idx)
      index_r <= io_wdata[7:0];
  end

  //////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      power_r  <= pcs_pkg::POWER_RST;
      intgen_r <= pcs_pkg::INTGEN_RST;
      cscint_r <= pcs_pkg::CSCINT_RST;
      global_r <= pcs_pkg::GLOBAL_RST;
      misc1_r  <= 1'b0;
    end else if (wr_go) begin
      case (reg_sel)
        pcs_pkg::IDX_POWER:  power_r  <= wr_val;
        pcs_pkg::IDX_INTGEN: intgen_r <= wr_val;
        pcs_pkg::IDX_CSCINT: cscint_r <= wr_val;
        pcs_pkg::IDX_GLOBAL: global_r <= wr_val[3:0];
        pcs_pkg::IDX_MISC1:  misc1_r  <= wr_val[0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // live status
  logic io_card, ring_en, present, pwr_want, pwr_on, ack_wr;
  logic cd_chg, rdy_rise, warn_in, dead_in, stsc_fall;
  logic [3:0] csc_set, csc_vis, csc_clr;
  logic [7:0] status_v, ident_v, rd_v;

  assign io_card  = intgen_r[pcs_pkg::IG_IOCARD];
  assign ring_en  = intgen_r[pcs_pkg::IG_RING];
  assign present  = !s2_r.cd1_n && !s2_r.cd2_n;
  assign pwr_want = power_r[pcs_pkg::POW_SUPPLY] &&
                    (!power_r[pcs_pkg::POW_AUTO] || present);
  assign pwr_on   = !supply_3v3_enable_n || !supply_5v_enable_n;
  assign ack_wr   = global_r[pcs_pkg::GL_ACKMODE];
  assign ident_v  = {pcs_pkg::IFACE_MEM_IO, 2'h0, REVISION};
  assign status_v = {1'b0, pwr_on, s2_r.ready, s2_r.wp,
                     !s2_r.cd2_n, !s2_r.cd1_n,
                     (io_card ? 1'b0 : s2_r.bvd2),
                     ((io_card && !ring_en) ? s2_r.bvd1_stschg_n : s2_r.bvd1_stschg_n)};

  //////////////////////////////////////////////////////////////////////////
  // status change flags; a set in the clearing cycle survives
  assign cd_chg    = (s2_r.cd1_n != s3_r.cd1_n) || (s2_r.cd2_n != s3_r.cd2_n);
  assign rdy_rise  = s2_r.ready && !s3_r.ready;
  assign warn_in   = {s2_r.bvd2, s2_r.bvd1_stschg_n} == 2'h1;
  assign dead_in   = !s2_r.bvd1_stschg_n;
  assign stsc_fall = !s2_r.bvd1_stschg_n && s3_r.bvd1_stschg_n;
  assign csc_set[pcs_pkg::CSC_CD]    = cd_chg && cscint_r[pcs_pkg::CSC_CD];
  assign csc_set[pcs_pkg::CSC_RDY]   = !io_card && rdy_rise &&
                                       cscint_r[pcs_pkg::CSC_RDY];
  assign csc_set[pcs_pkg::CSC_BWARN] = !io_card && cscint_r[pcs_pkg::CSC_BWARN] &&
                                       warn_in && !({s3_r.bvd2, s3_r.bvd1_stschg_n} == 2'h1);
  assign csc_set[pcs_pkg::CSC_BDEAD] = cscint_r[pcs_pkg::CSC_BDEAD] &&
                                       (io_card ? stsc_fall
                                                : (dead_in && s3_r.bvd1_stschg_n));
  // clears: write-one in explicit mode, whole register on read otherwise
  always_comb begin
    csc_clr = 4'h0;
    if (wr_go && reg_sel == pcs_pkg::IDX_CSC && ack_wr)
      csc_clr = wr_val[3:0];
    if (rd_dat && reg_sel == pcs_pkg::IDX_CSC && !ack_wr)
      csc_clr = 4'hF;
    if (evt_cd_cleared)
      csc_clr[pcs_pkg::CSC_CD] = 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (!nrst)
      csc_r <= pcs_pkg::CSC_RST;
    else
      csc_r <= (csc_r & ~csc_clr) | csc_set;
  end

  // visible flags; disabled sources and io-card-only zeros masked
  assign csc_vis = csc_r & cscint_r[3:0] &
                   {1'b1, !io_card, !io_card, !(io_card && ring_en)};

  // cleared card detect flag asks the event register to drop its flags
  always_ff @(posedge mclk) begin
    if (!nrst)
      evt_cd_clear_r <= 1'b0;
    else
      evt_cd_clear_r <= csc_clr[pcs_pkg::CSC_CD] && !evt_cd_cleared &&
                        csc_r[pcs_pkg::CSC_CD];
  end

  //////////////////////////////////////////////////////////////////////////
  // read path, one cycle after the strobe
  always_comb begin
    rd_v = 8'h00;
    case (reg_sel)
      pcs_pkg::IDX_IDENT:  rd_v = ident_v;
      pcs_pkg::IDX_STATUS: rd_v = status_v;
      pcs_pkg::IDX_POWER:  rd_v = power_r;
      pcs_pkg::IDX_INTGEN: rd_v = intgen_r;
      pcs_pkg::IDX_CSC:    rd_v = {4'h0, csc_vis};
      pcs_pkg::IDX_CSCINT: rd_v = cscint_r;
      pcs_pkg::IDX_GLOBAL: rd_v = {4'h0, global_r};
      pcs_pkg::IDX_MISC1:  rd_v = {7'h00, misc1_r};
      default:             rd_v = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      io_rdata_r  <= 8'h00;
      io_rvalid_r <= 1'b0;
    end else begin
      io_rvalid_r <= io_rd && (hit_idx || hit_dat);
      io_rdata_r  <= (io_rd && hit_idx) ? index_r : (rd_dat ? rd_v : 8'h00);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // socket power and card control outputs
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      supply_3v3_enable_n   <= 1'b1;
      supply_5v_enable_n    <= 1'b1;
      prog_voltage_enable_0 <= 1'b0;
      prog_voltage_enable_1 <= 1'b0;
    end else begin
      supply_3v3_enable_n   <= !(pwr_want && misc1_r);
      supply_5v_enable_n    <= !(pwr_want && !misc1_r);
      prog_voltage_enable_0 <= pwr_want && power_r[0];
      prog_voltage_enable_1 <= pwr_want && power_r[1];
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      card_output_drive_enable <= 1'b0;
      card_reset_r             <= 1'b1;
      card_write_block_r       <= 1'b0;
      ring_output_n            <= 1'b1;
    end else begin
      card_output_drive_enable <= power_r[pcs_pkg::POW_DRIVE];
      card_reset_r             <= !intgen_r[pcs_pkg::IG_RESET];
      card_write_block_r       <= mem_wp_bit;
      ring_output_n            <= !(io_card && ring_en) ||
                                  s2_r.bvd1_stschg_n;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt routing; status change level held until cleared, no re-raise; card irq follows ireq_n only for an io card with isa_irq_en set
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      card_irq_r <= 16'h0000;
      status_change_irq_route_r  <= 16'h0000;
      csc_inta_r <= 1'b0;
    end else begin
      card_irq_r <= (isa_irq_en && io_card && !s2_r.ireq_n) ?
                    route(intgen_r[3:0]) : 16'h0000;
      status_change_irq_route_r  <= (|csc_vis) ? route(cscint_r[7:4]) : 16'h0000;
      csc_inta_r <= (|csc_vis) && (route(cscint_r[7:4]) == 16'h0000);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  sequence pow_on_s;
    pwr_want && misc1_r;
  endsequence
  sequence rd_clear_s;
    rd_dat && reg_sel == pcs_pkg::IDX_CSC && !ack_wr && csc_set == 4'h0;
  endsequence
  sequence ack_clear_s;
    wr_go && reg_sel == pcs_pkg::IDX_CSC && ack_wr;
  endsequence

  base_gate_a: assert property (@(posedge mclk) disable iff (!nrst)
    io_rd && !base_ok |=> !io_rvalid_r) else $error("port answered without base");
  ident_val_a: assert property (@(posedge mclk) disable iff (!nrst)
    rd_dat && reg_sel == pcs_pkg::IDX_IDENT |=> io_rdata_r[7:4] == 4'h8)
    else $error("ident field wrong");
  supply_sel_a: assert property (@(posedge mclk) disable iff (!nrst)
    pow_on_s |=> !supply_3v3_enable_n && supply_5v_enable_n)
    else $error("3v3 supply not chosen");
  supply_off_a: assert property (@(posedge mclk) disable iff (!nrst)
    !power_r[pcs_pkg::POW_SUPPLY] |=> supply_3v3_enable_n && supply_5v_enable_n &&
    !prog_voltage_enable_0 && !prog_voltage_enable_1) else $error("power not off");
  reset_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    !intgen_r[pcs_pkg::IG_RESET] [*2] |-> card_reset_r) else $error("card reset dropped");
  csc_mask_a: assert property (@(posedge mclk) disable iff (!nrst)
    rd_dat && reg_sel == pcs_pkg::IDX_CSC |=> (io_rdata_r[3:0] & ~$past(cscint_r[3:0])) == 4'h0)
    else $error("disabled flag visible");
  read_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
    rd_clear_s |=> csc_r == 4'h0) else $error("read did not clear");
  irq_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    (|csc_vis) && $stable(cscint_r) |=> status_change_irq_route_r == route($past(cscint_r[7:4])))
    else $error("status irq not held");
  drive_en_a: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(power_r[pcs_pkg::POW_DRIVE]) |-> ##1 card_output_drive_enable)
    else $error("drive enable late");
  auto_pow_a: assert property (@(posedge mclk) disable iff (!nrst)
    power_r[pcs_pkg::POW_AUTO] && !present |=> supply_3v3_enable_n && supply_5v_enable_n)
    else $error("auto switch ignored");

  // read-side, pin-side and write-one clear checks; status reads see synced pins of the strobe cycle
  ring_pass_a: assert property (@(posedge mclk) disable iff (!nrst)
    io_card && ring_en |=> ring_output_n == $past(s2_r.bvd1_stschg_n))
    else $error("ring not passed");
  io_mask_a: assert property (@(posedge mclk) disable iff (!nrst)
    rd_dat && reg_sel == pcs_pkg::IDX_CSC && io_card |=> io_rdata_r[2:1] == 2'h0)
    else $error("io card flags visible");
  detect_inv_a: assert property (@(posedge mclk) disable iff (!nrst)
    rd_dat && reg_sel == pcs_pkg::IDX_STATUS |=>
    io_rdata_r[3:2] == ~{$past(s2_r.cd2_n), $past(s2_r.cd1_n)}) else $error("detect not inverse");
  power_flag_a: assert property (@(posedge mclk) disable iff (!nrst)
    rd_dat && reg_sel == pcs_pkg::IDX_STATUS |=> io_rdata_r[6] == $past(pwr_on))
    else $error("power flag wrong");
  isa_gate_a: assert property (@(posedge mclk) disable iff (!nrst)
    !isa_irq_en |=> card_irq_r == 16'h0000)
    else $error("card irq without enable");
  ack_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
    ack_clear_s |=> (csc_r & $past(wr_val[3:0] & ~csc_set)) == 4'h0)
    else $error("write one did not clear");

endmodule

// [test/pcs_card_model.sv]
// behavioural 16-bit card sitting in the socket
// assumes the bench sets its levels; an empty socket reads all pull-ups
////////////////////////////////////////////////////////////////////////
module pcs_card_model (
  // levels chosen by the bench
  input  wire logic       present,
  input  wire logic       rdy,
  input  wire logic       wp_in,
  input  wire logic [1:0] batt,
  input  wire logic       irq_n,
  // socket pins
  output pcs_pkg::pcs_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ns;
  // no card: every line floats to its pull-up, so detects read high
  assign pins = present ? {rdy, wp_in, 2'b00, batt[0], batt[1], irq_n} : 7'h7F;
endmodule

// [test/pcs_socket_setup_test.sv]
// self-checking bench of the 16-bit socket setup bank
// assumes the card model on the pins; host port driven 1 ns after mclk rises
////////////////////////////////////////////////////////////////////////
module pcs_socket_setup_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] REV = 4'hA; // arbitrary value
  logic        mclk = 1'b0, nrst = 1'b0, io_wr = 1'b0, io_rd = 1'b0, io_wide = 1'b0;
  logic [15:0] io_addr = 16'h0000, io_wdata = 16'h0000, legacy_base = 16'h0000;
  logic        index_range_sel = 1'b0, isa_irq_en = 1'b0, mem_wp_bit = 1'b0;
  logic        evt_cd_cleared = 1'b0, present = 1'b0, rdy = 1'b0, wp_in = 1'b1, irq_n = 1'b1;
  logic [1:0]  batt = 2'h3, win = 2'h0;
  logic [7:0]  io_rdata_r;
  logic        io_rvalid_r, evt_cd_clear_r, supply_3v3_enable_n, supply_5v_enable_n;
  logic        prog_voltage_enable_0, prog_voltage_enable_1, card_output_drive_enable;
  logic        card_reset_r, card_write_block_r, ring_output_n, csc_inta_r;
  logic [15:0] card_irq_r, status_change_irq_route_r;
  pcs_pkg::pcs_pins_t pins;
  int          err_count = 0, num_checks = 0;

  always #20 mclk = ~mclk;

  pcs_socket_setup #(.REVISION(REV)) uut (.mclk, .nrst, .io_addr, .io_wr, .io_rd, .io_wide,
    .io_wdata, .io_rdata_r, .io_rvalid_r, .legacy_base, .index_range_sel, .isa_irq_en,
    .mem_wp_bit, .evt_cd_cleared, .evt_cd_clear_r, .pins, .supply_3v3_enable_n,
    .supply_5v_enable_n, .prog_voltage_enable_0, .prog_voltage_enable_1,
    .card_output_drive_enable, .card_reset_r, .card_write_block_r, .ring_output_n,
    .card_irq_r, .status_change_irq_route_r, .csc_inta_r);
  pcs_card_model card (.present, .rdy, .wp_in, .batt, .irq_n, .pins);

  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // idle cycle after each strobe so a strobe never toggles twice in one step
  task automatic wr(logic [15:0] a, logic [15:0] d, logic w);
    io_addr = a;
    io_wdata = d;
    io_wide = w;
    io_wr = 1'b1;
    tick(1);
    io_wr = 1'b0;
    tick(1);
  endtask
  task automatic setr(logic [5:0] idx, logic [7:0] d);
    wr(legacy_base, {d, win, idx}, 1'b1);
  endtask
  task automatic rchk(string what, logic [5:0] idx, logic [7:0] exp);
    wr(legacy_base, {8'h00, win, idx}, 1'b0);
    io_addr = legacy_base + 16'h0001;
    io_rd = 1'b1;
    tick(1);
    io_rd = 1'b0;
    chk({what, " valid"}, 16'h0001, {15'h0, io_rvalid_r});
    chk(what, {8'h00, exp}, {8'h00, io_rdata_r});
  endtask
  task automatic pw(logic [3:0] exp);
    chk("supply pins", {12'h0, exp}, {12'h0, supply_3v3_enable_n, supply_5v_enable_n,
      prog_voltage_enable_1, prog_voltage_enable_0});
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_decode;
    io_addr = 16'h03E1;
    io_rd = 1'b1;
    tick(1);
    io_rd = 1'b0;
    chk("decode off", 16'h0000, {15'h0, io_rvalid_r});
    legacy_base = pcs_pkg::PORT_BASE_B;
    rchk("ident", pcs_pkg::IDX_IDENT, {pcs_pkg::IFACE_MEM_IO, 2'b00, REV});
    index_range_sel = 1'b1;
    rchk("low window", pcs_pkg::IDX_IDENT, 8'h00);
    win = pcs_pkg::IDX_WIN_HIGH;
    rchk("high window", pcs_pkg::IDX_IDENT, {pcs_pkg::IFACE_MEM_IO, 2'b00, REV});
  endtask
  task automatic t_power;
    setr(pcs_pkg::IDX_MISC1, 8'h00);
    setr(pcs_pkg::IDX_POWER, 8'h90);
    pw(4'h8);
    chk("drive on", 16'h0001, {15'h0, card_output_drive_enable});
    rchk("status on", pcs_pkg::IDX_STATUS, 8'h73);
    setr(pcs_pkg::IDX_MISC1, 8'h01);
    setr(pcs_pkg::IDX_POWER, 8'h93);
    pw(4'h7);
    setr(pcs_pkg::IDX_POWER, 8'h00);
    pw(4'hC);
    chk("drive off", 16'h0000, {15'h0, card_output_drive_enable});
    rchk("status off", pcs_pkg::IDX_STATUS, 8'h33);
    // auto switching keeps an empty socket unpowered
    setr(pcs_pkg::IDX_POWER, 8'hB0);
    pw(4'hC);
  endtask
  task automatic t_csc;
    setr(pcs_pkg::IDX_CSCINT, 8'h3F);
    setr(pcs_pkg::IDX_GLOBAL, 8'h00);
    setr(pcs_pkg::IDX_INTGEN, 8'h40);
    chk("reset released", 16'h0000, {15'h0, card_reset_r});
    present = 1'b1;
    tick(6);
    pw(4'h4);
    rchk("status card", pcs_pkg::IDX_STATUS, 8'h5F);
    chk("wp not blocking", 16'h0000, {15'h0, card_write_block_r});
    mem_wp_bit = 1'b1;
    tick(2);
    chk("wp blocking", 16'h0001, {15'h0, card_write_block_r});
    chk("csc irq3", 16'h0008, status_change_irq_route_r);
    rchk("cd change", pcs_pkg::IDX_CSC, 8'h08);
    chk("event clear pulse", 16'h0001, {15'h0, evt_cd_clear_r});
    rchk("read cleared", pcs_pkg::IDX_CSC, 8'h00);
    chk("status_change_irq_route off", 16'h0000, status_change_irq_route_r);
    setr(pcs_pkg::IDX_GLOBAL, 8'h04);
    rdy = 1'b1;
    batt = 2'h1;
    tick(6);
    rchk("ready warn", pcs_pkg::IDX_CSC, 8'h06);
    rchk("no read clear", pcs_pkg::IDX_CSC, 8'h06);
    setr(pcs_pkg::IDX_CSC, 8'h04);
    rchk("ack one", pcs_pkg::IDX_CSC, 8'h02);
    chk("irq held", 16'h0008, status_change_irq_route_r);
    setr(pcs_pkg::IDX_CSC, 8'h02);
    chk("irq released", 16'h0000, status_change_irq_route_r);
    setr(pcs_pkg::IDX_CSCINT, 8'h3E);
    batt = 2'h0;
    tick(6);
    rchk("dead masked", pcs_pkg::IDX_CSC, 8'h00);
    batt = 2'h3;
    tick(6);
  endtask
  task automatic t_ring;
    setr(pcs_pkg::IDX_CSCINT, 8'h3F);
    setr(pcs_pkg::IDX_INTGEN, 8'h60);
    batt = 2'h2;
    tick(6);
    rchk("io status", pcs_pkg::IDX_STATUS, 8'h7C);
    rchk("stschg low", pcs_pkg::IDX_CSC, 8'h01);
    setr(pcs_pkg::IDX_INTGEN, 8'hE0);
    tick(3);
    chk("ring out", 16'h0000, {15'h0, ring_output_n});
    rchk("ring masks", pcs_pkg::IDX_CSC, 8'h00);
  endtask
  task automatic t_route;
    logic [3:0] codes [11] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE,
      4'hF};
    isa_irq_en = 1'b1;
    irq_n = 1'b0;
    foreach (codes[i]) begin
      setr(pcs_pkg::IDX_INTGEN, {4'h6, codes[i]});
      chk("card irq", codes[i] == 4'h0 ? 16'h0000 : 16'h0001 << codes[i], card_irq_r);
    end
    isa_irq_en = 1'b0;
    tick(2);
    chk("isa gate", 16'h0000, card_irq_r);
    isa_irq_en = 1'b1;
    setr(pcs_pkg::IDX_INTGEN, 8'h4F);
    chk("memory card", 16'h0000, card_irq_r);
  endtask
  task automatic t_event;
    setr(pcs_pkg::IDX_CSC, 8'h0F);
    present = 1'b0;
    tick(6);
    chk("cd irq", 16'h0008, status_change_irq_route_r);
    evt_cd_cleared = 1'b1;
    tick(1);
    evt_cd_cleared = 1'b0;
    chk("no echo clear", 16'h0000, {15'h0, evt_cd_clear_r});
    rchk("event cleared", pcs_pkg::IDX_CSC, 8'h00);
    setr(pcs_pkg::IDX_CSCINT, 8'h0F);
    present = 1'b1;
    tick(6);
    chk("inta pending", 16'h0001, {15'h0, csc_inta_r});
    chk("no irq line", 16'h0000, status_change_irq_route_r);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    end_of_test;
  end
  initial begin
    tick(5);
    nrst = 1'b1;
    chk("reset held", 16'h0001, {15'h0, card_reset_r});
    t_decode;
    t_power;
    t_csc;
    t_ring;
    t_route;
    t_event;
    end_of_test;
  end
endmodule
